// ===== hw/emt_tester.sv
// Memory march tester top: sequencer, checkers and result stores.
// Contract
// - Initialise controller and program mapper for the chosen row before testing.
// - Tested row is 16K locations of 16 bits, all covered.
// - Write random word, read it back at once, compare, then step.
// - After march, reread whole row and compare to catch imaging.
// - Errors accumulate across passes; only explicit restart clears them.
// - Failing-bit mask bit n marks data bit Dn; zero when clean.
// - Failure count stays zero when clean, plus one per failing pass.
// - Tested in 4K blocks; image flags report A13 and A12.
// - Image: line low writing zeros, then high writing ones, stepping lower bits.
// - Image readback flags locations differing from the intended value.
// - Retention: write zeros, wait 60 s, read; then same with ones.
// - Retention stops at the first failing location in either phase.
// - Image and retention capture first failing address and bits, else invalid.
// - Four 16K rows each keep their own mask and failure count.
`timescale 1ns/1ps
module emt_tester
    import emt_pkg::*;
#(
    parameter longint RETAIN_CYCLES = EMT_RETAIN_CYC
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic restart,
    input wire logic [1:0] test_mode,
    input wire logic [1:0] row_sel,
    input wire logic image_line,
    output logic setup_req,
    input wire logic setup_ack,
    output logic [1:0] setup_row,
    output logic busy,
    output logic done,
    output logic ram_cs,
    output logic ram_we,
    output logic [13:0] ram_addr,
    output logic [15:0] ram_wdata,
    output logic ram_wdata_oe,
    input wire logic [15:0] ram_rdata,
    output logic [15:0] fail_mask [EMT_ROWS],
    output logic [15:0] fail_count [EMT_ROWS],
    output logic [1:0] image_err,
    output logic first_bad_valid,
    output logic [13:0] first_bad_address,
    output logic [15:0] first_bad_data_bits
);
    // ==========================================
    // State
    typedef enum logic [3:0] {
        EMT_IDLE, EMT_SETUP, EMT_WR, EMT_RD, EMT_SCAN, EMT_WAIT, EMT_FIN
    } emt_state_t;

    emt_state_t st_q;
    emt_mode_t mode_q;
    logic [1:0] row_q;
    logic line_q;
    logic [13:0] addr_q;
    logic phase_q;
    logic [15:0] lfsr_q;
    logic [15:0] scan_lfsr_q;
    logic [39:0] wait_q;
    logic pass_bad_q;
    logic issued_q;
    logic [15:0] diff;
    logic [15:0] expect_v;
    logic [15:0] pattern_v;
    logic [13:0] phys_addr;
    logic [13:0] last_v;
    logic bit_hi;

    emt_mem_if mi();

    emt_ram_access u_acc (
        .mclk(mclk),
        .rst_n(rst_n),
        .m(mi),
        .ram_cs(ram_cs),
        .ram_we(ram_we),
        .ram_addr(ram_addr),
        .ram_wdata(ram_wdata),
        .ram_wdata_oe(ram_wdata_oe),
        .ram_rdata(ram_rdata)
    );

    // ==========================================
    // Address and pattern
    // Image mode places the line under test on A13 or A12 and steps the 12 lower bits.
    // An image sweep ends after 8K logical addresses, since only bit 12 and below are used.
    always_comb begin
        bit_hi = addr_q[12];
        last_v = EMT_LAST_ADDR;
        if (mode_q == EMT_MODE_IMAGE) begin
            last_v = {2'h1, EMT_LAST_LOW};
            phys_addr = line_q ? {bit_hi, 1'b0, addr_q[11:0]} : {1'b0, bit_hi, addr_q[11:0]};
            pattern_v = bit_hi ? EMT_ONES : EMT_ZEROS;
        end else if (mode_q == EMT_MODE_RETAIN) begin
            phys_addr = addr_q;
            pattern_v = phase_q ? EMT_ONES : EMT_ZEROS;
        end else begin
            phys_addr = addr_q;
            pattern_v = lfsr_q;
        end
        expect_v = (mode_q == EMT_MODE_MARCH && st_q == EMT_SCAN) ? scan_lfsr_q : pattern_v;
        diff = mi.rdata ^ expect_v;
    end

    assign mi.req = (st_q == EMT_WR || st_q == EMT_RD || st_q == EMT_SCAN) && !issued_q;
    assign mi.we = (st_q == EMT_WR);
    assign mi.addr = phys_addr;
    assign mi.wdata = pattern_v;
    assign setup_req = (st_q == EMT_SETUP);
    assign setup_row = row_q;
    assign busy = (st_q != EMT_IDLE);

    // ==========================================
    // Sequencer
    // Steps march, image and retention sequences; the last address ends each sweep, or a failing retention read ends the scan early.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= EMT_IDLE;
            mode_q <= EMT_MODE_MARCH;
            row_q <= 2'd0;
            line_q <= 1'b0;
            addr_q <= 14'h0000;
            phase_q <= 1'b0;
            issued_q <= 1'b0;
            wait_q <= 40'd0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (mi.req) begin
                issued_q <= 1'b1;
            end
            unique case (st_q)
                EMT_IDLE: begin
                    if (start) begin
                        mode_q <= emt_mode_t'(test_mode);
                        row_q <= row_sel;
                        line_q <= image_line;
                        st_q <= EMT_SETUP;
                    end
                end
                EMT_SETUP: begin
                    if (setup_ack) begin
                        addr_q <= 14'h0000;
                        phase_q <= 1'b0;
                        issued_q <= 1'b0;
                        st_q <= EMT_WR;
                    end
                end
                EMT_WR: begin
                    if (mi.done) begin
                        issued_q <= 1'b0;
                        if (mode_q == EMT_MODE_MARCH) begin
                            st_q <= EMT_RD;
                        end else if (addr_q == last_v) begin
                            addr_q <= 14'h0000;
                            wait_q <= 40'd0;
                            st_q <= (mode_q == EMT_MODE_RETAIN) ? EMT_WAIT : EMT_SCAN;
                        end else begin
                            addr_q <= addr_q + 14'h0001;
                        end
                    end
                end
                EMT_RD: begin
                    if (mi.done) begin
                        issued_q <= 1'b0;
                        if (addr_q == EMT_LAST_ADDR) begin
                            addr_q <= 14'h0000;
                            st_q <= EMT_SCAN;
                        end else begin
                            addr_q <= addr_q + 14'h0001;
                            st_q <= EMT_WR;
                        end
                    end
                end
                EMT_WAIT: begin
                    wait_q <= wait_q + 40'd1;
                    if (wait_q == 40'(RETAIN_CYCLES - 1)) begin
                        st_q <= EMT_SCAN;
                    end
                end
                EMT_SCAN: begin
                    if (mi.done) begin
                        issued_q <= 1'b0;
                        if (mode_q == EMT_MODE_RETAIN && diff != EMT_ZEROS) begin
                            st_q <= EMT_FIN;
                        end else if (addr_q == last_v) begin
                            addr_q <= 14'h0000;
                            if (mode_q == EMT_MODE_RETAIN && !phase_q) begin
                                phase_q <= 1'b1;
                                st_q <= EMT_WR;
                            end else begin
                                st_q <= EMT_FIN;
                            end
                        end else begin
                            addr_q <= addr_q + 14'h0001;
                        end
                    end
                end
                EMT_FIN: begin
                    done <= 1'b1;
                    st_q <= EMT_IDLE;
                end
                default: st_q <= EMT_IDLE;
            endcase
        end
    end

    // ==========================================
    // Random data
    // Two LFSRs share one seed: one feeds writes, one regenerates them for the reread.
    always_ff @(posedge mclk) begin
        if (!rst_n || st_q == EMT_SETUP) begin
            lfsr_q <= EMT_LFSR_SEED;
            scan_lfsr_q <= EMT_LFSR_SEED;
        end else begin
            if (st_q == EMT_RD && mi.done) begin
                lfsr_q <= (lfsr_q >> 1) ^ (lfsr_q[0] ? EMT_LFSR_TAPS : EMT_ZEROS);
            end
            if (st_q == EMT_SCAN && mi.done) begin
                scan_lfsr_q <= (scan_lfsr_q >> 1) ^ (scan_lfsr_q[0] ? EMT_LFSR_TAPS : EMT_ZEROS);
            end
        end
    end

    // ==========================================
    // Results
    logic chk;
    assign chk = mi.done && (st_q == EMT_RD || st_q == EMT_SCAN);

    // Per-row masks and counts accumulate until restart; a pass adds at most one failure.
    genvar g;
    generate
        for (g = 0; g < EMT_ROWS; g++) begin : g_row
            always_ff @(posedge mclk) begin
                if (!rst_n || restart) begin
                    fail_mask[g] <= EMT_MASK_RST;
                    fail_count[g] <= EMT_CNT_RST;
                end else if (row_q == 2'(g)) begin
                    if (chk) begin
                        fail_mask[g] <= fail_mask[g] | diff;
                    end
                    if (st_q == EMT_FIN && (pass_bad_q || (chk && diff != EMT_ZEROS))) begin
                        fail_count[g] <= fail_count[g] + 16'h0001;
                    end
                end
            end
        end
    endgenerate

    // Pass flag, image flags and first-failure capture; they start clean on each start.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pass_bad_q <= 1'b0;
            image_err <= 2'b00;
            first_bad_valid <= 1'b0;
            first_bad_address <= 14'h0000;
            first_bad_data_bits <= 16'h0000;
        end else if (st_q == EMT_IDLE && start) begin
            pass_bad_q <= 1'b0;
            image_err <= 2'b00;
            first_bad_valid <= 1'b0;
            first_bad_address <= 14'h0000;
            first_bad_data_bits <= 16'h0000;
        end else if (chk && diff != EMT_ZEROS) begin
            pass_bad_q <= 1'b1;
            if (mode_q == EMT_MODE_IMAGE) begin
                image_err[line_q] <= 1'b1;
            end
            if (mode_q != EMT_MODE_MARCH && !first_bad_valid) begin
                first_bad_valid <= 1'b1;
                first_bad_address <= phys_addr;
                first_bad_data_bits <= diff;
            end
        end
    end
endmodule

// ===== hw/emt_pkg.sv
// Package with constants and types for the emulation memory march tester.
package emt_pkg;
    // ==========================================
    // Geometry
    localparam int EMT_AW = 14;
    localparam int EMT_DW = 16;
    localparam int EMT_ROWS = 4;
    localparam logic [13:0] EMT_LAST_ADDR = 14'h3FFF;
    localparam logic [11:0] EMT_LAST_LOW = 12'hFFF;
    // ==========================================
    // Reset values and seeds
    localparam logic [15:0] EMT_MASK_RST = 16'h0000;
    localparam logic [15:0] EMT_CNT_RST = 16'h0000;
    localparam logic [15:0] EMT_LFSR_SEED = 16'hACE1;
    localparam logic [15:0] EMT_LFSR_TAPS = 16'hB400;
    localparam logic [15:0] EMT_ZEROS = 16'h0000;
    localparam logic [15:0] EMT_ONES = 16'hFFFF;
    // ==========================================
    // Timing
    localparam longint EMT_CLK_HZ = 100000000;
    localparam longint EMT_RETAIN_S = 60;
    localparam longint EMT_RETAIN_CYC = EMT_RETAIN_S * EMT_CLK_HZ;
    // ==========================================
    // Modes
    typedef enum logic [1:0] {
        EMT_MODE_MARCH,
        EMT_MODE_IMAGE,
        EMT_MODE_RETAIN
    } emt_mode_t;
endpackage

// ===== hw/emt_mem_if.sv
// Interface carrying the RAM port between the tester sequencer and its access unit.
`timescale 1ns/1ps
interface emt_mem_if;
    import emt_pkg::*;
    logic req;
    logic we;
    logic [13:0] addr;
    logic [15:0] wdata;
    logic done;
    logic [15:0] rdata;
    modport seq (output req, output we, output addr, output wdata, input done, input rdata);
    modport acc (input req, input we, input addr, input wdata, output done, output rdata);
endinterface

// ===== hw/emt_ram_access.sv
// RAM access unit: turns one request into one RAM cycle on the pins.
`timescale 1ns/1ps
module emt_ram_access
    import emt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    emt_mem_if.acc m,
    output logic ram_cs,
    output logic ram_we,
    output logic [13:0] ram_addr,
    output logic [15:0] ram_wdata,
    output logic ram_wdata_oe,
    input wire logic [15:0] ram_rdata
);
    // ==========================================
    // Access phases
    logic busy_q;
    logic [15:0] rd_s1_q;
    logic [15:0] rd_s2_q;

    // Drives the RAM for one cycle, then waits two cycles for synchronised read data.
    logic [1:0] ph_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            ph_q <= 2'd0;
            ram_cs <= 1'b0;
            ram_we <= 1'b0;
            ram_addr <= 14'h0000;
            ram_wdata <= 16'h0000;
            ram_wdata_oe <= 1'b0;
        end else if (!busy_q && m.req) begin
            busy_q <= 1'b1;
            ph_q <= 2'd0;
            ram_cs <= 1'b1;
            ram_we <= m.we;
            ram_addr <= m.addr;
            ram_wdata <= m.wdata;
            ram_wdata_oe <= m.we;
        end else if (busy_q) begin
            ram_cs <= 1'b0;
            ram_we <= 1'b0;
            ram_wdata_oe <= 1'b0;
            ph_q <= ph_q + 2'd1;
            if (ph_q == 2'd2) begin
                busy_q <= 1'b0;
            end
        end
    end

    // Read data passes two flip-flops since the RAM lives off this clock's timing.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_s1_q <= 16'h0000;
            rd_s2_q <= 16'h0000;
        end else begin
            rd_s1_q <= ram_rdata;
            rd_s2_q <= rd_s1_q;
        end
    end

    assign m.done = busy_q && (ph_q == 2'd2);
    assign m.rdata = rd_s2_q;
endmodule

// ===== testbench/emt_ram_model.sv
// Behavioural RAM row with injectable address and cell faults.
`timescale 1ns/1ps
module emt_ram_model (
    input wire logic mclk,
    input wire logic ram_cs,
    input wire logic ram_we,
    input wire logic [13:0] ram_addr,
    input wire logic [15:0] ram_wdata,
    input wire logic ram_wdata_oe,
    input wire logic [1:0] fault_mode,
    output logic [15:0] ram_rdata
);
    logic [15:0] mem [16384];
    logic [15:0] hold_q;
    logic [1:0] hcnt_q;
    logic [13:0] eff;
    logic [15:0] rd_val;
    // ==========================================
    // Fault 1 floats A12 high; fault 2 sets bit 3 of location 5 on reads.
    always_comb begin
        eff = ram_addr | ((fault_mode == 2'h1) ? 14'h1000 : 14'h0000);
        rd_val = mem[eff] | ((fault_mode == 2'h2 && eff == 14'h0005) ? 16'h0008 : 16'h0000);
    end
    // Read data holds for the select cycle and two more, then turns to garbage.
    assign ram_rdata = (ram_cs && !ram_we) ? rd_val : ((hcnt_q != 2'h0) ? hold_q : ~hold_q);
    // Writes land only when the tester drives the data bus.
    always_ff @(posedge mclk) begin
        if (ram_cs && ram_we && ram_wdata_oe) begin
            mem[eff] <= ram_wdata;
        end
        if (ram_cs && !ram_we) begin
            hold_q <= rd_val;
            hcnt_q <= 2'h2;
        end else if (hcnt_q != 2'h0) begin
            hcnt_q <= hcnt_q - 2'h1;
        end
    end
endmodule

// ===== testbench/emt_tester_props.sv
// Port checker for the march tester.
`timescale 1ns/1ps
module emt_tester_props
    import emt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic setup_req,
    input wire logic setup_ack,
    input wire logic busy,
    input wire logic done,
    input wire logic ram_cs,
    input wire logic ram_we,
    input wire logic ram_wdata_oe,
    input wire logic [15:0] fail_mask [EMT_ROWS],
    input wire logic [15:0] fail_count [EMT_ROWS]
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Access spacing, setup handshake, completion and result accumulation.
    cs_spacing_a: assert property (ram_cs |=> !ram_cs [*3])
        else $error("ram select closer than four cycles");
    oe_write_a: assert property (ram_wdata_oe |-> ram_cs && ram_we)
        else $error("data bus driven outside a write");
    done_pulse_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    done_busy_a: assert property (done |-> $past(busy))
        else $error("done without a running test");
    setup_busy_a: assert property (setup_req |-> busy)
        else $error("setup request while idle");
    setup_hold_a: assert property (setup_req && !setup_ack |=> setup_req)
        else $error("setup request dropped before ack");
    setup_noram_a: assert property (setup_req |-> !ram_cs)
        else $error("ram access before setup");
    restart_clr_a: assert property (restart |=> fail_mask[0] == 16'h0000 && fail_count[0] == 16'h0000)
        else $error("restart did not clear results");
    mask_accum_a: assert property (!restart |=> (fail_mask[0] & $past(fail_mask[0])) == $past(fail_mask[0]))
        else $error("failing bit lost without restart");
    count_step_a: assert property ($changed(fail_count[0]) && !$past(restart) |-> fail_count[0] == $past(fail_count[0]) + 16'h0001)
        else $error("failure count not stepped by one");
    cover property (done);
    cover property (setup_req && setup_ack);
    cover property (restart);
endmodule
bind emt_tester emt_tester_props emt_tester_props_inst (.mclk, .rst_n, .restart, .setup_req,
    .setup_ack, .busy, .done, .ram_cs, .ram_we, .ram_wdata_oe, .fail_mask, .fail_count);

// ===== testbench/testbench.sv
// Self-checking testbench for the march tester.
`timescale 1ns/1ps
module testbench;
    import emt_pkg::*;
    logic mclk, rst_n, start, restart, image_line, setup_ack, setup_req, busy, done;
    logic ram_cs, ram_we, ram_wdata_oe, first_bad_valid;
    logic [1:0] test_mode, row_sel, setup_row, image_err, fault_mode;
    logic [13:0] ram_addr, first_bad_address;
    logic [15:0] ram_wdata, ram_rdata, first_bad_data_bits, w0;
    logic [15:0] fail_mask [EMT_ROWS];
    logic [15:0] fail_count [EMT_ROWS];
    int n_errors, cmp_count;
    emt_tester #(.RETAIN_CYCLES(20)) emt_tester_inst (.mclk, .rst_n, .start, .restart,
        .test_mode, .row_sel, .image_line, .setup_req, .setup_ack, .setup_row, .busy, .done,
        .ram_cs, .ram_we, .ram_addr, .ram_wdata, .ram_wdata_oe, .ram_rdata, .fail_mask,
        .fail_count, .image_err, .first_bad_valid, .first_bad_address, .first_bad_data_bits);
    emt_ram_model emt_ram_model_inst (.mclk, .ram_cs, .ram_we, .ram_addr, .ram_wdata,
        .ram_wdata_oe, .fault_mode, .ram_rdata);
    // ==========================================
    // Clock at 100 MHz.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Waits for ram select (0), done (1) or setup request (2), bounded.
    task automatic wait_on(input int sel);
        int k;
        k = 0;
        @(negedge mclk);
        while ((sel == 0 ? ram_cs : sel == 1 ? done : setup_req) !== 1'b1) begin
            @(negedge mclk);
            k++;
            if (k > 80000) begin
                chk("wait", 16'h0001, 16'h0000);
                give_verdict();
            end
        end
    endtask
    // Starts a test and completes the setup handshake.
    task automatic go(input logic [1:0] md, input logic [1:0] row);
        test_mode = md;
        row_sel = row;
        start = 1'b1;
        wait_on(2);
        start = 1'b0;
        chk("setup_row", 16'(row), 16'(setup_row));
        @(negedge mclk);
        chk("setup_hold", 16'h0001, 16'(setup_req));
        setup_ack = 1'b1;
        @(negedge mclk);
        setup_ack = 1'b0;
    endtask
    // Holds reset for two cycles.
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
    endtask
    // Clean results after reset.
    task automatic t_reset();
        for (int r = 0; r < EMT_ROWS; r++) begin
            chk("fail_mask", EMT_MASK_RST, fail_mask[r]);
            chk("fail_count", EMT_CNT_RST, fail_count[r]);
        end
        chk("busy", 16'h0000, 16'(busy));
        chk("first_bad_valid", 16'h0000, 16'(first_bad_valid));
        $display("test reset finished");
    endtask
    // Write, immediate readback, refused start, abort and reseed.
    task automatic t_march();
        go(EMT_MODE_MARCH, 2'h3);
        wait_on(0);
        chk("wr0_we", 16'h0001, 16'(ram_we && ram_wdata_oe));
        chk("wr0_addr", 16'h0000, 16'(ram_addr));
        w0 = ram_wdata;
        wait_on(0);
        chk("rd0_we", 16'h0000, 16'(ram_we));
        chk("rd0_addr", 16'h0000, 16'(ram_addr));
        wait_on(0);
        chk("wr1_addr", 16'h0001, 16'(ram_addr));
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        chk("refused", 16'h0000, 16'(setup_req));
        do_reset();
        chk("busy_abort", 16'h0000, 16'(busy));
        go(EMT_MODE_MARCH, 2'h3);
        wait_on(0);
        chk("reseed", w0, ram_wdata);
        do_reset();
        $display("test march finished");
    endtask
    // Image test of A12 with that line floating high.
    task automatic t_image();
        fault_mode = 2'h1;
        go(EMT_MODE_IMAGE, 2'h0);
        wait_on(1);
        chk("image_err", 16'h0001, 16'(image_err));
        chk("fb_valid", 16'h0001, 16'(first_bad_valid));
        chk("fb_addr", 16'h0000, 16'(first_bad_address));
        chk("fb_bits", EMT_ONES, first_bad_data_bits);
        chk("other_row", EMT_MASK_RST, fail_mask[1]);
        chk("mask_row0", EMT_ONES, fail_mask[0]);
        chk("count_row0", 16'h0001, fail_count[0]);
        $display("test image finished");
    endtask
    // Retention test aborts at a cell that loses a zero.
    task automatic t_retain();
        fault_mode = 2'h2;
        go(EMT_MODE_RETAIN, 2'h2);
        wait_on(1);
        chk("fb_addr", 16'h0005, 16'(first_bad_address));
        chk("fb_bits", 16'h0008, first_bad_data_bits);
        chk("last_addr", 16'h0005, 16'(ram_addr));
        chk("mask_row2", 16'h0008, fail_mask[2]);
        chk("count_row2", 16'h0001, fail_count[2]);
        @(negedge mclk);
        chk("busy_end", 16'h0000, 16'(busy));
        $display("test retention finished");
    endtask
    // Restart clears cumulative results but not the first failure.
    task automatic t_restart();
        restart = 1'b1;
        @(negedge mclk);
        restart = 1'b0;
        for (int r = 0; r < EMT_ROWS; r++) begin
            chk("mask_clr", EMT_MASK_RST, fail_mask[r]);
            chk("count_clr", EMT_CNT_RST, fail_count[r]);
        end
        chk("fb_kept", 16'h0005, 16'(first_bad_address));
        $display("test restart finished");
    endtask
    // Main sequence.
    initial begin
        n_errors = 0;
        cmp_count = 0;
        start = 1'b0;
        restart = 1'b0;
        test_mode = 2'h0;
        row_sel = 2'h0;
        image_line = 1'b0;
        setup_ack = 1'b0;
        fault_mode = 2'h0;
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_march();
        t_image();
        t_retain();
        t_restart();
        give_verdict();
    end
endmodule
